// ---- via_consts.svh ----
`ifndef VIA_CONSTS_SVH
`define VIA_CONSTS_SVH
// vector table byte offsets
`define VEC_BASE 8'he0
`define VEC_TRAP 8'hfe
`define TRAP_SLOT 4'hf
`define PORT_SLOT 4'h1
`define PERIPH_SRCS 13
// opcode and error handling
`define TRAP_OPC 8'h00
`define STACK_LIMIT 8'h6f
`define STACK_ERR_PC 15'h7fff
`define ISR_ENTRY 15'h00ff
`define PROG_BYTES 2048
`define PL_PINS 8
// register byte offsets and fields
`define ADR_CTRL 5'h00
`define ADR_PEN 5'h04
`define ADR_PEDGE 5'h08
`define ADR_PPEND 5'h0c
`define ADR_VIS 5'h10
`define CTRL_GIE 0
`define CTRL_PORT_GROUP_IRQ_ENABLE 1
`define CTRL_RST 8'h00
`endif

// ---- via_pkg.sv ----
`include "via_consts.svh"
package via_pkg;
  typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_VFETCH = 1'b1} seq_t;

  typedef struct packed {
    logic global_int_enable;
    logic port_group_irq_enable;
    logic [`PL_PINS-1:0] pin_en;
    logic [`PL_PINS-1:0] pin_edge;
    logic trap_pend;
    seq_t seq;
    logic [7:0] vis_off;
    logic [14:0] vec_addr;
    logic pc_load;
    logic [14:0] pc_val;
    logic push;
    logic [14:0] push_addr;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] fetch_data;
    logic wake;
    logic wake_isr;
  } arb_state_t;

  typedef struct packed {
    logic [`PL_PINS-1:0] sync1;
    logic [`PL_PINS-1:0] sync2;
    logic [`PL_PINS-1:0] prev;
    logic [`PL_PINS-1:0] pend;
  } edge_state_t;
endpackage

// ---- port_edge_unit.sv ----
`timescale 1ns/1ps
`include "via_consts.svh"
module port_edge_unit
  import via_pkg::*;
#(
  parameter int W = `PL_PINS
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_i,
  input wire logic [W-1:0] edge_sel,
  input wire logic [W-1:0] clr_mask,
  output logic [W-1:0] pending
);
  edge_state_t state_q;
  edge_state_t state_d;
  logic [W-1:0] trig;

  if (W != `PL_PINS)
  begin : g_chk
    $error("port width must match the state layout");
  end

  always_comb
  begin
    state_d = state_q;
    state_d.sync1 = pin_i;
    state_d.sync2 = state_q.sync1;
    state_d.prev = state_q.sync2;
    // 1 selects falling edge, 0 rising
    trig = (state_q.sync2 & ~state_q.prev & ~edge_sel)
         | (~state_q.sync2 & state_q.prev & edge_sel);
    // a new edge wins over a software clear in the same cycle
    state_d.pend = (state_q.pend & ~clr_mask) | trig;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pending = state_q.pend;
endmodule

// ---- vectored_interrupt_arbiter.sv ----
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "via_consts.svh"
// Notes on behaviour
// - dispatch yields even e0..fe, highest active
// - trap pending forces dispatch value fe
// - value replaces only low pc byte
// - fetch vector from memory into pc
// - nothing active selects default e0 slot
// - higher rank sits at higher slot
// - reset clears trap pending flag
// - trap sets trap pending flag
// - only clear instruction or reset clears flag
// - trap flag invisible to software
// - all-zero opcode load raises trap
// - fetch outside program memory returns zero
// - over-popped stack loads pc 7fff
// - trap keeps gie; pending flag masks maskables
// - only a trap preempts trap routine
// - trap pushes address of trap opcode
// - trap taken at once before maskables
// - maskable never preempts maskable routine
// - eight port pin edge interrupts, one vector
// - per-pin enable bit
// - per-pin edge select
// - per-pin pending latch, no group flag
// - port irq needs group enable and gie
// - wake resumes inline or via routine
// - return-from-interrupt sets gie, pops pc
module vectored_interrupt_arbiter
  import via_pkg::*;
#(
  parameter int PROG_BYTES = `PROG_BYTES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`PL_PINS-1:0] port_pin_i,
  input wire logic [`PERIPH_SRCS-1:0] periph_irq_i,
  input wire logic ir_load_i,
  input wire logic [7:0] ir_opcode_i,
  input wire logic [14:0] ir_addr_i,
  input wire logic [14:0] pc_i,
  input wire logic vis_exec_i,
  input wire logic clear_nmi_exec_i,
  input wire logic return_from_interrupt_instr_exec_i,
  input wire logic ret_exec_i,
  input wire logic int_ack_i,
  input wire logic [7:0] stack_ptr_i,
  input wire logic [14:0] stack_data_i,
  output logic vec_rd_req_o,
  output logic [14:0] vec_rd_addr_o,
  input wire logic vec_rd_ack_i,
  input wire logic [14:0] vec_rd_data_i,
  input wire logic [14:0] fetch_addr_i,
  input wire logic [7:0] fetch_raw_i,
  output logic [7:0] fetch_data_o,
  output logic int_req_o,
  output logic pc_load_o,
  output logic [14:0] pc_load_val_o,
  output logic push_o,
  output logic [14:0] push_addr_o,
  input wire logic halted_i,
  output logic wake_o,
  output logic wake_isr_o
);
  localparam logic [15:0] PROG_LIM = 16'(PROG_BYTES);

  if (PROG_BYTES < 1 || PROG_BYTES > 32768)
  begin : g_chk
    $error("program size must be 1..32768 bytes");
  end

  arb_state_t state_q;
  arb_state_t state_d;
  logic [`PL_PINS-1:0] pin_pend;
  logic [`PL_PINS-1:0] pin_clr;
  logic [15:0] act;
  logic trap_ev;
  logic bus_hit;
  logic bus_wr;
  logic pop;
  logic vec_done;
  logic ack_take;

  // highest active slot wins; slot 0 is the default vector
  function automatic logic [3:0] pick_slot(input logic [15:0] a);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 1; i < 16; i++)
    begin
      if (a[i])
      begin
        s = 4'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [7:0] slot_offset(input logic [3:0] s);
    return `VEC_BASE | {3'h0, s, 1'b0};
  endfunction

  function automatic logic [31:0] reg_read(input logic [4:0] adr, input arb_state_t s,
                                           input logic [`PL_PINS-1:0] pp);
    logic [31:0] r;
    r = 32'h0;
    case (adr)
      `ADR_CTRL: r = {30'h0, s.port_group_irq_enable, s.global_int_enable};
      `ADR_PEN: r = {24'h0, s.pin_en};
      `ADR_PEDGE: r = {24'h0, s.pin_edge};
      `ADR_PPEND: r = {24'h0, pp};
      `ADR_VIS: r = {24'h0, s.vis_off};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  port_edge_unit #(
    .W(`PL_PINS)
  ) u_port (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_i(port_pin_i),
    .edge_sel(state_q.pin_edge),
    .clr_mask(pin_clr),
    .pending(pin_pend)
  );

  assign bus_hit = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  assign bus_wr = bus_hit & wb_we_i & state_q.ack & wb_sel_i[0];
  assign pin_clr = (bus_wr && wb_adr_i == `ADR_PPEND) ? wb_dat_i[`PL_PINS-1:0] : '0;
  assign trap_ev = ir_load_i && ir_opcode_i == `TRAP_OPC;
  assign pop = return_from_interrupt_instr_exec_i | ret_exec_i;
  assign vec_done = state_q.seq == SEQ_VFETCH && vec_rd_ack_i;

  always_comb
  begin
    act = 16'h0;
    act[`TRAP_SLOT] = state_q.trap_pend;
    act[`PORT_SLOT] = state_q.port_group_irq_enable & |(pin_pend & state_q.pin_en);
    act[14:2] = periph_irq_i;
  end

  // trap pending blocks all maskables; cleared gie blocks nesting
  assign int_req_o = state_q.global_int_enable & ~state_q.trap_pend & |act[14:1];
  assign ack_take = int_ack_i & int_req_o & ~trap_ev;

  always_comb
  begin
    state_d = state_q;
    state_d.pc_load = 1'b0;
    state_d.push = 1'b0;
    state_d.ack = bus_hit & ~state_q.ack;
    state_d.rdata = state_q.ack ? 32'h0 : reg_read(wb_adr_i, state_q, pin_pend);
    if (bus_wr && wb_adr_i == `ADR_CTRL)
    begin
      state_d.global_int_enable = wb_dat_i[`CTRL_GIE];
      state_d.port_group_irq_enable = wb_dat_i[`CTRL_PORT_GROUP_IRQ_ENABLE];
    end
    if (bus_wr && wb_adr_i == `ADR_PEN)
    begin
      state_d.pin_en = wb_dat_i[`PL_PINS-1:0];
    end
    if (bus_wr && wb_adr_i == `ADR_PEDGE)
    begin
      state_d.pin_edge = wb_dat_i[`PL_PINS-1:0];
    end
    // zero bytes outside program memory decode as the trap opcode
    state_d.fetch_data = ({1'b0, fetch_addr_i} >= PROG_LIM) ? `TRAP_OPC : fetch_raw_i;
    if (clear_nmi_exec_i)
    begin
      state_d.trap_pend = 1'b0;
    end
    if (pop)
    begin
      state_d.pc_load = 1'b1;
      state_d.pc_val = (stack_ptr_i > `STACK_LIMIT) ? `STACK_ERR_PC : stack_data_i;
      if (return_from_interrupt_instr_exec_i)
      begin
        state_d.global_int_enable = 1'b1;
      end
    end
    if (ack_take)
    begin
      state_d.global_int_enable = 1'b0;
      state_d.push = 1'b1;
      state_d.push_addr = pc_i;
      state_d.pc_load = 1'b1;
      state_d.pc_val = `ISR_ENTRY;
    end
    case (state_q.seq)
      SEQ_IDLE:
      begin
        if (vis_exec_i)
        begin
          state_d.vis_off = slot_offset(pick_slot(act));
          state_d.vec_addr = {pc_i[14:8], slot_offset(pick_slot(act))};
          state_d.seq = SEQ_VFETCH;
        end
      end
      SEQ_VFETCH:
      begin
        if (vec_rd_ack_i)
        begin
          state_d.pc_load = 1'b1;
          state_d.pc_val = vec_rd_data_i;
          state_d.seq = SEQ_IDLE;
        end
      end
      default: state_d.seq = SEQ_IDLE;
    endcase
    // trap is taken at once, even inside a trap routine; gie untouched
    if (trap_ev)
    begin
      state_d.trap_pend = 1'b1;
      state_d.push = 1'b1;
      state_d.push_addr = ir_addr_i;
      state_d.pc_load = 1'b1;
      state_d.pc_val = `ISR_ENTRY;
    end
    // wake level while halted; isr path only if the interrupt can be taken
    state_d.wake = halted_i & |(pin_pend & state_q.pin_en);
    state_d.wake_isr = halted_i & |(pin_pend & state_q.pin_en) & state_q.port_group_irq_enable
                       & state_q.global_int_enable & ~state_q.trap_pend;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.rdata;
  assign vec_rd_req_o = state_q.seq == SEQ_VFETCH;
  assign vec_rd_addr_o = state_q.vec_addr;
  assign fetch_data_o = state_q.fetch_data;
  assign pc_load_o = state_q.pc_load;
  assign pc_load_val_o = state_q.pc_val;
  assign push_o = state_q.push;
  assign push_addr_o = state_q.push_addr;
  assign wake_o = state_q.wake;
  assign wake_isr_o = state_q.wake_isr;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_vis_even_range: assert property (
    state_q.seq == SEQ_IDLE && vis_exec_i |=> state_q.vis_off[0] == 1'b0
      && state_q.vis_off >= `VEC_BASE && vec_rd_req_o)
    else $error("dispatch value not even in range");

  a_vis_trap_top: assert property (
    state_q.seq == SEQ_IDLE && vis_exec_i && state_q.trap_pend |=> state_q.vis_off == `VEC_TRAP)
    else $error("trap pending did not give top slot");

  a_vis_default: assert property (
    state_q.seq == SEQ_IDLE && vis_exec_i && act == 16'h0 |=> state_q.vis_off == `VEC_BASE)
    else $error("idle dispatch missed default slot");

  a_vis_upper: assert property (
    state_q.seq == SEQ_IDLE && vis_exec_i |=> vec_rd_addr_o[14:8] == $past(pc_i[14:8])
      && vec_rd_addr_o[7:0] == state_q.vis_off)
    else $error("vector address upper byte changed");

  a_vec_load: assert property (
    vec_done && !trap_ev |=> pc_load_o && pc_load_val_o == $past(vec_rd_data_i))
    else $error("fetched vector not loaded");

  a_trap_set: assert property (
    trap_ev |=> state_q.trap_pend && push_o && push_addr_o == $past(ir_addr_i)
      && pc_load_val_o == `ISR_ENTRY)
    else $error("trap opcode not taken");

  a_trap_hold: assert property (
    state_q.trap_pend && !clear_nmi_exec_i |=> state_q.trap_pend)
    else $error("trap flag lost without clear");

  a_trap_clear: assert property (
    clear_nmi_exec_i && !trap_ev |=> !state_q.trap_pend)
    else $error("clear instruction did not clear flag");

  a_reset_flag: assert property (@(posedge ref_clk) disable iff (1'b0)
    reset |=> !state_q.trap_pend)
    else $error("reset left trap flag set");

  a_trap_masks: assert property (
    state_q.trap_pend |-> !int_req_o)
    else $error("maskable request under trap");

  a_trap_gie: assert property (
    trap_ev && !pop && !bus_wr |=> state_q.global_int_enable == $past(state_q.global_int_enable))
    else $error("trap altered gie");

  a_ack_gie: assert property (
    ack_take |=> !state_q.global_int_enable && push_o && push_addr_o == $past(pc_i) ##1 !push_o)
    else $error("maskable ack mishandled");

  a_stack_err: assert property (
    pop && stack_ptr_i > `STACK_LIMIT && !trap_ev && !ack_take && !vec_done
      |=> pc_load_o && pc_load_val_o == `STACK_ERR_PC)
    else $error("over-pop did not load 7fff");

  a_fetch_zero: assert property (
    {1'b0, fetch_addr_i} >= PROG_LIM |=> fetch_data_o == `TRAP_OPC)
    else $error("missing memory not read as zero");

  a_port_gate: assert property (
    int_req_o && periph_irq_i == '0 |-> state_q.port_group_irq_enable && state_q.global_int_enable)
    else $error("port request without enables");
endmodule

// ---- core_model.sv ----
`timescale 1ns/1ps
module core_model
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic vec_rd_req_o,
  input wire logic [14:0] vec_rd_addr_o,
  input wire logic [3:0] stall,
  output logic vec_rd_ack_i,
  output logic [14:0] vec_rd_data_i
);
  logic [3:0] wait_q;
  // idle data keeps toggling so a stale capture never looks right
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wait_q <= 4'h0;
      vec_rd_ack_i <= 1'b0;
      vec_rd_data_i <= 15'h2aaa;
    end
    else if (!vec_rd_req_o || vec_rd_ack_i)
    begin
      wait_q <= 4'h0;
      vec_rd_ack_i <= 1'b0;
      vec_rd_data_i <= ~vec_rd_data_i;
    end
    else if (wait_q == stall)
    begin
      vec_rd_ack_i <= 1'b1;
      // page bits scrambled so a wrong high byte is seen
      vec_rd_data_i <= {vec_rd_addr_o[14:8] ^ 7'h02, vec_rd_addr_o[7:0]};
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
      vec_rd_data_i <= ~vec_rd_data_i;
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
`include "via_consts.svh"
module tb;
  localparam int PB = 2048;
  localparam int VECTOR_DISPATCH_INSTR = 0, TRAP = 1, ACK = 2, CLR = 3, RETURN_FROM_INTERRUPT_INSTR = 4, RET = 5;
  logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ir_load_i, vis_exec_i;
  logic clear_nmi_exec_i, return_from_interrupt_instr_exec_i, ret_exec_i, int_ack_i, vec_rd_req_o, vec_rd_ack_i;
  logic int_req_o, pc_load_o, push_o, halted_i, wake_o, wake_isr_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, stall;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] ir_opcode_i, stack_ptr_i, fetch_raw_i, fetch_data_o;
  logic [`PL_PINS-1:0] port_pin_i;
  logic [`PERIPH_SRCS-1:0] periph_irq_i;
  logic [14:0] ir_addr_i, pc_i, stack_data_i, vec_rd_addr_o, vec_rd_data_i, fetch_addr_i;
  logic [14:0] pc_load_val_o, push_addr_o;
  int err_total, samples_checked, cyc_count;

  vectored_interrupt_arbiter #(.PROG_BYTES(PB)) vectored_interrupt_arbiter_inst
  (
    .ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .port_pin_i, .periph_irq_i, .ir_load_i, .ir_opcode_i, .ir_addr_i,
    .pc_i, .vis_exec_i, .clear_nmi_exec_i, .return_from_interrupt_instr_exec_i, .ret_exec_i, .int_ack_i,
    .stack_ptr_i, .stack_data_i, .vec_rd_req_o, .vec_rd_addr_o, .vec_rd_ack_i,
    .vec_rd_data_i, .fetch_addr_i, .fetch_raw_i, .fetch_data_o, .int_req_o, .pc_load_o,
    .pc_load_val_o, .push_o, .push_addr_o, .halted_i, .wake_o, .wake_isr_o
  );
  core_model core_model_inst
  (
    .ref_clk, .reset, .vec_rd_req_o, .vec_rd_addr_o, .stall, .vec_rd_ack_i, .vec_rd_data_i
  );

  task automatic final_report();
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    // a missing ack counts against the run instead of passing silently
    if (n >= 20)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      VECTOR_DISPATCH_INSTR: vis_exec_i <= 1'b1;
      TRAP: ir_load_i <= 1'b1;
      ACK: int_ack_i <= 1'b1;
      CLR: clear_nmi_exec_i <= 1'b1;
      RETURN_FROM_INTERRUPT_INSTR: return_from_interrupt_instr_exec_i <= 1'b1;
      default: ret_exec_i <= 1'b1;
    endcase
    @(posedge ref_clk);
    {vis_exec_i, ir_load_i, int_ack_i, clear_nmi_exec_i, return_from_interrupt_instr_exec_i, ret_exec_i} <= '0;
  endtask
  task automatic wait_pc(input logic [14:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (pc_load_o !== 1'b1 && n < 20);
    chk({16'h0, pc_load_o, pc_load_val_o}, {16'h0, 1'b1, exp});
  endtask
  // pc page is 01, the model maps it to 03
  task automatic dispatch(input logic [`PERIPH_SRCS-1:0] irq, input logic [7:0] off);
    @(posedge ref_clk);
    periph_irq_i <= irq;
    stall <= {2'b00, off[2:1]};
    pulse(VECTOR_DISPATCH_INSTR);
    wait_pc({7'h03, off});
  endtask
  task automatic ret_chk(input int k, input logic [7:0] sp, input logic [14:0] exp);
    @(posedge ref_clk);
    stack_ptr_i <= sp;
    stack_data_i <= 15'h0789;
    pulse(k);
    wait_pc(exp);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc_count++;
    if (cyc_count == 4000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    {err_total, samples_checked, cyc_count} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, ir_load_i, vis_exec_i, clear_nmi_exec_i} = '0;
    {return_from_interrupt_instr_exec_i, ret_exec_i, int_ack_i, halted_i, wb_adr_i, wb_dat_i, port_pin_i} = '0;
    {ir_opcode_i, stack_ptr_i, fetch_raw_i, periph_irq_i, ir_addr_i, stack_data_i} = '0;
    {fetch_addr_i, stall} = '0;
    wb_sel_i = 4'hf;
    pc_i = 15'h0123;
    reset = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int a = 0; a < 6; a++) rchk(5'(a * 4), 32'h0);
    wb(1'b1, 5'h04, 32'h1234_5608);
    rchk(5'h04, 32'h8);
    dispatch('0, 8'he0);
    for (int i = 0; i < 13; i++) dispatch(13'(1 << i), 8'(8'he4 + 2 * i));
    dispatch(13'h1fff, 8'hfc);
    rchk(5'h10, 32'hfc);
    dispatch(13'h0005, 8'he8);
    wb(1'b1, 5'h00, 32'h1);
    @(posedge ref_clk);
    ir_addr_i <= 15'h0456;
    pulse(TRAP);
    wait_pc(15'h00ff);
    chk({16'h0, push_o, push_addr_o}, {16'h0, 1'b1, 15'h0456});
    chk(32'(int_req_o), 32'h0);
    rchk(5'h00, 32'h1);
    dispatch(13'h0005, 8'hfe);
    pulse(ACK);
    @(negedge ref_clk);
    chk(32'(pc_load_o), 32'h0);
    pulse(TRAP);
    wait_pc(15'h00ff);
    repeat (4) @(negedge ref_clk);
    chk(32'(int_req_o), 32'h0);
    pulse(CLR);
    @(negedge ref_clk);
    chk(32'(int_req_o), 32'h1);
    pulse(ACK);
    wait_pc(15'h00ff);
    chk({16'h0, push_o, push_addr_o}, {16'h0, 1'b1, 15'h0123});
    chk(32'(int_req_o), 32'h0);
    rchk(5'h00, 32'h0);
    ret_chk(RETURN_FROM_INTERRUPT_INSTR, 8'h20, 15'h0789);
    rchk(5'h00, 32'h1);
    ret_chk(RET, 8'h6f, 15'h0789);
    ret_chk(RET, 8'h70, 15'h7fff);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      fetch_addr_i <= 15'(PB - 1 + k);
      fetch_raw_i <= 8'ha5;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'(fetch_data_o), (k == 0) ? 32'ha5 : 32'h0);
    end
    wb(1'b1, 5'h08, 32'h08);
    wb(1'b1, 5'h04, 32'h09);
    wb(1'b1, 5'h00, 32'h3);
    @(posedge ref_clk);
    periph_irq_i <= '0;
    port_pin_i <= 8'h09;
    repeat (5) @(posedge ref_clk);
    rchk(5'h0c, 32'h01);
    @(posedge ref_clk);
    port_pin_i <= 8'h00;
    repeat (5) @(posedge ref_clk);
    rchk(5'h0c, 32'h09);
    @(negedge ref_clk);
    chk(32'(int_req_o), 32'h1);
    dispatch('0, 8'he2);
    @(posedge ref_clk);
    halted_i <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(32'({wake_o, wake_isr_o}), 32'h3);
    wb(1'b1, 5'h00, 32'h2);
    @(negedge ref_clk);
    chk(32'({int_req_o, wake_o, wake_isr_o}), 32'h2);
    wb(1'b1, 5'h0c, 32'h09);
    rchk(5'h0c, 32'h0);
    wb(1'b1, 5'h04, 32'h0);
    wb(1'b1, 5'h00, 32'h3);
    @(posedge ref_clk);
    port_pin_i <= 8'h01;
    repeat (5) @(posedge ref_clk);
    rchk(5'h0c, 32'h01);
    @(negedge ref_clk);
    chk(32'({int_req_o, wake_o}), 32'h0);
    pulse(TRAP);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    periph_irq_i <= 13'h0001;
    wb(1'b1, 5'h00, 32'h1);
    @(negedge ref_clk);
    chk(32'(int_req_o), 32'h1);
    final_report();
  end
endmodule
